// file: rtl/cst_timers.v
// Cyclic sense timers, switch selection and switch supply shutdown
// Notes on behaviour
// - Code 000 stops timer, outputs low; 110 high
// - Code 110 holds controlled output statically high
// - On codes 001-101 give 0.1/0.3/1/10/20 ms
// - Period codes give 10ms to 2s; 111 reserved
// - On-time bits 6:4, period 2:0, others zero
// - Restart clears switch config and timer fields
// - Wake sampling and sensing share one timer
// - Timers and switch config zero on resets
// - Bit 6 inhibits overvoltage shutdown of switches
// - Bit 5 inhibits undervoltage shutdown of switches
// - Bit 4 restores pre-fault state after fault
// - Shutdown bits survive restart, cleared otherwise
// - Switch two bits 6:4, switch one 2:0
// - Switch codes: off, on, timers, duty channels
// - Overcurrent or overtemperature clears switch config
// - Wake filtered 16us at end of on-time
//
// Design decision made here: the address-and-strobe port.
`include "cst_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module cst_timers #(
  parameter TICK_CYC = `CST_TICK_CYC,
  parameter FILT_CYC = `CST_WK_FILT_CYC
) (
  input  wire       core_clk,
  input  wire       nrst,
  input  wire       soft_rst,
  input  wire       restart,
  input  wire [6:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata_q,
  input  wire       supply_ov,
  input  wire       supply_uv,
  input  wire [1:0] sw_fault,
  input  wire [2:0] switch_three_config,
  input  wire [2:0] switch_four_config,
  input  wire       duty_channel_one,
  input  wire       duty_channel_two,
  input  wire [1:0] wake_cyc_sel,
  input  wire       wake_in,
  output reg  [3:0] high_side_output_q,
  output reg        wake_event_q,
  output reg        supply_clear_q
);

  // On-time in ticks of 10 us; reserved and static codes give zero
  // Scaled at full width first, then cut, so no factor wraps in 18 bits
  function [17:0] on_ticks;
    input [2:0]  code;
    reg   [31:0] t;
    begin
      case (code)
        3'h1:    t = 32'd1000 * `CST_ON1_US / `CST_TICK_NS;
        3'h2:    t = 32'd1000 * `CST_ON2_US / `CST_TICK_NS;
        3'h3:    t = 32'd1000 * `CST_ON3_US / `CST_TICK_NS;
        3'h4:    t = 32'd1000 * `CST_ON4_US / `CST_TICK_NS;
        3'h5:    t = 32'd1000 * `CST_ON5_US / `CST_TICK_NS;
        default: t = 32'h00000000;
      endcase
      on_ticks = t[17:0];
    end
  endfunction

  // Period in ticks of 10 us; the longest period needs all 18 bits
  function [17:0] per_ticks;
    input [2:0]  code;
    reg   [31:0] t;
    begin
      case (code)
        3'h0:    t = 32'd1000000 * `CST_PER0_MS / `CST_TICK_NS;
        3'h1:    t = 32'd1000000 * `CST_PER1_MS / `CST_TICK_NS;
        3'h2:    t = 32'd1000000 * `CST_PER2_MS / `CST_TICK_NS;
        3'h3:    t = 32'd1000000 * `CST_PER3_MS / `CST_TICK_NS;
        3'h4:    t = 32'd1000000 * `CST_PER4_MS / `CST_TICK_NS;
        3'h5:    t = 32'd1000000 * `CST_PER5_MS / `CST_TICK_NS;
        3'h6:    t = 32'd1000000 * `CST_PER6_MS / `CST_TICK_NS;
        default: t = 32'h00000001;
      endcase
      per_ticks = t[17:0];
    end
  endfunction

  // Timer runs only with a pulsing on-time and a valid period
  function running;
    input [2:0] on;
    input [2:0] per;
    begin
      running = (on != `CST_ON_LOW) && (on != `CST_ON_HIGH) &&
                (on != `CST_ON_RSVD) && (per != `CST_PER_RSVD);
    end
  endfunction

  // Level of one switch from its configuration
  function sw_level;
    input [2:0] cfg;
    input       ta;
    input       tb;
    input       d1;
    input       d2;
    begin
      case (cfg)
        `CST_SW_ON:    sw_level = 1'b1;
        `CST_SW_TMR_A: sw_level = ta;
        `CST_SW_TMR_B: sw_level = tb;
        `CST_SW_DUTY1: sw_level = d1;
        `CST_SW_DUTY2: sw_level = d2;
        default:       sw_level = 1'b0;
      endcase
    end
  endfunction

  // Per-timer fields, counters and levels
  reg  [2:0]  on_q [0:1];
  reg  [2:0]  per_q [0:1];
  reg  [17:0] cnt_q [0:1];
  reg  [1:0]  lvl_q;
  reg  [9:0]  pre_q;
  reg  [2:0]  sd_q;
  reg  [2:0]  sw1_q;
  reg  [2:0]  sw2_q;
  reg         fault_q;
  reg  [10:0] wk_cnt_q;
  // Decode and strobe nets
  wire        tick;
  wire        fault_now;
  wire        fault_rise;
  wire [1:0]  on_end;
  wire        sel_end;
  wire        any_rst;
  wire [6:0]  tmr_addr [0:1];
  // Loop indices, one per process so each has a single driver
  integer     i;
  integer     j;

  // Timer register addresses, indexed by timer
  assign tmr_addr[0] = `CST_ADDR_TMR_A;
  assign tmr_addr[1] = `CST_ADDR_TMR_B;
  assign any_rst     = ~nrst | soft_rst;
  assign tick        = (pre_q == TICK_CYC - 1);

  // Supply fault gated by the two inhibit bits
  assign fault_now  = (supply_ov & ~sd_q[2]) |
                      (supply_uv & ~sd_q[1]);
  assign fault_rise = fault_now & ~fault_q;

  // Last tick of the on-time of each running timer
  assign on_end[0] = tick & running(on_q[0], per_q[0]) &
                     (cnt_q[0] == on_ticks(on_q[0]) - 18'h00001);
  assign on_end[1] = tick & running(on_q[1], per_q[1]) &
                     (cnt_q[1] == on_ticks(on_q[1]) - 18'h00001);
  assign sel_end   = (wake_cyc_sel == `CST_WK_TMR_A) ? on_end[0] :
                     (wake_cyc_sel == `CST_WK_TMR_B) ? on_end[1] : 1'b0;

  // Shared 10 us time base
  always @(posedge core_clk) begin
    if (!nrst || pre_q == TICK_CYC - 1) begin
      pre_q <= 10'h000;
    end else begin
      pre_q <= pre_q + 10'h001;
    end
  end

  // Timer fields and period counters
  always @(posedge core_clk) begin
    for (i = 0; i < 2; i = i + 1) begin
      if (any_rst || restart) begin
        on_q[i]  <= `CST_RST_FLD;
        per_q[i] <= `CST_RST_FLD;
        cnt_q[i] <= 18'h00000;
      end else if (reg_wr && reg_addr == tmr_addr[i]) begin
        on_q[i]  <= reg_wdata[`CST_ON_HI:`CST_ON_LO];
        per_q[i] <= reg_wdata[`CST_PER_HI:`CST_PER_LO];
        cnt_q[i] <= 18'h00000;
      end else if (!running(on_q[i], per_q[i])) begin
        cnt_q[i] <= 18'h00000;
      end else if (tick) begin
        // Compare with >= so a shorter new period cannot overrun
        if (cnt_q[i] >= per_ticks(per_q[i]) - 18'h00001) begin
          cnt_q[i] <= 18'h00000;
        end else begin
          cnt_q[i] <= cnt_q[i] + 18'h00001;
        end
      end
    end
  end

  // Timer output levels, one per timer
  // Registered so a switch never sees a glitch from the count compare
  always @(posedge core_clk) begin
    for (j = 0; j < 2; j = j + 1) begin
      if (any_rst || restart) begin
        lvl_q[j] <= 1'b0;
      end else if (running(on_q[j], per_q[j])) begin
        lvl_q[j] <= (cnt_q[j] < on_ticks(on_q[j]));
      end else begin
        lvl_q[j] <= (on_q[j] == `CST_ON_HIGH);
      end
    end
  end

  // Shutdown control; only power-on and soft reset clear it
  always @(posedge core_clk) begin
    if (any_rst) begin
      sd_q <= `CST_RST_SD;
    end else if (reg_wr && reg_addr == `CST_ADDR_SD_CTRL) begin
      sd_q <= reg_wdata[`CST_SD_OV_BIT:`CST_SD_REC_BIT];
    end
  end

  // Switch pair configuration; hardware clears win over writes for safety
  always @(posedge core_clk) begin
    if (any_rst || restart) begin
      sw1_q <= `CST_RST_SW;
      sw2_q <= `CST_RST_SW;
    end else begin
      // Supply fault onset clears only when recovery is off
      if (sw_fault[0] || (fault_rise && !sd_q[0])) begin
        sw1_q <= `CST_SW_OFF;
      end else if (reg_wr && reg_addr == `CST_ADDR_SW_PAIR) begin
        sw1_q <= reg_wdata[`CST_SW1_HI:`CST_SW1_LO];
      end
      if (sw_fault[1] || (fault_rise && !sd_q[0])) begin
        sw2_q <= `CST_SW_OFF;
      end else if (reg_wr && reg_addr == `CST_ADDR_SW_PAIR) begin
        sw2_q <= reg_wdata[`CST_SW2_HI:`CST_SW2_LO];
      end
    end
  end

  // Fault edge tracking and clear request for the far switch pair
  // Only the gated level is tracked, so an inhibited fault never clears
  always @(posedge core_clk) begin
    if (any_rst) begin
      fault_q        <= 1'b0;
      supply_clear_q <= 1'b0;
    end else begin
      fault_q        <= fault_now;
      supply_clear_q <= fault_rise & ~sd_q[0];
    end
  end

  // Outputs forced low during fault; configs held give recovery
  always @(posedge core_clk) begin
    if (any_rst || restart || fault_now) begin
      high_side_output_q <= 4'h0;
    end else begin
      high_side_output_q[0] <= sw_level(sw1_q, lvl_q[0], lvl_q[1],
                                        duty_channel_one, duty_channel_two);
      high_side_output_q[1] <= sw_level(sw2_q, lvl_q[0], lvl_q[1],
                                        duty_channel_one, duty_channel_two);
      // Switches three and four take their config from outside
      high_side_output_q[2] <= sw_level(switch_three_config, lvl_q[0], lvl_q[1],
                                        duty_channel_one, duty_channel_two);
      high_side_output_q[3] <= sw_level(switch_four_config, lvl_q[0], lvl_q[1],
                                        duty_channel_one, duty_channel_two);
    end
  end

  // Wake high time, saturating at the filter length
  // Saturation keeps a long wake level from wrapping below the filter
  always @(posedge core_clk) begin
    if (any_rst || !wake_in) begin
      wk_cnt_q <= 11'h000;
    end else if (wk_cnt_q < FILT_CYC) begin
      wk_cnt_q <= wk_cnt_q + 11'h001;
    end
  end

  // Wake sampled at the end of the sensing pulse, same timer
  // Limitation: a wake rising late in the on-time misses that sample
  always @(posedge core_clk) begin
    if (any_rst) begin
      wake_event_q <= 1'b0;
    end else begin
      wake_event_q <= sel_end && (wk_cnt_q >= FILT_CYC);
    end
  end

  // Read data only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (!nrst || !reg_rd) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_addr == `CST_ADDR_TMR_A) begin
      reg_rdata_q <= {1'b0, on_q[0], 1'b0, per_q[0]};
    end else if (reg_addr == `CST_ADDR_TMR_B) begin
      reg_rdata_q <= {1'b0, on_q[1], 1'b0, per_q[1]};
    // Reserved bits are packed as zero
    end else if (reg_addr == `CST_ADDR_SD_CTRL) begin
      reg_rdata_q <= {1'b0, sd_q, 4'h0};
    end else if (reg_addr == `CST_ADDR_SW_PAIR) begin
      reg_rdata_q <= {1'b0, sw2_q, 1'b0, sw1_q};
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// file: rtl/cst_defs.vh
// Constants for the cyclic sense timers and switch shutdown block
`ifndef CST_DEFS_VH
`define CST_DEFS_VH

// Register addresses
`define CST_ADDR_TMR_A    7'h0C
`define CST_ADDR_TMR_B    7'h0D
`define CST_ADDR_SD_CTRL  7'h10
`define CST_ADDR_SW_PAIR  7'h14

// Reset values
`define CST_RST_TMR       8'h00
`define CST_RST_SD        3'h0
`define CST_RST_SW        3'h0
`define CST_RST_FLD       3'h0

// Timer control fields
`define CST_ON_HI         6
`define CST_ON_LO         4
`define CST_PER_HI        2
`define CST_PER_LO        0

// Shutdown control fields
`define CST_SD_OV_BIT     6
`define CST_SD_UV_BIT     5
`define CST_SD_REC_BIT    4

// Switch pair fields
`define CST_SW2_HI        6
`define CST_SW2_LO        4
`define CST_SW1_HI        2
`define CST_SW1_LO        0

// On-time and period codes
`define CST_ON_LOW        3'h0
`define CST_ON_HIGH       3'h6
`define CST_ON_RSVD       3'h7
`define CST_PER_RSVD      3'h7

// Switch configuration codes
`define CST_SW_OFF        3'h0
`define CST_SW_ON         3'h1
`define CST_SW_TMR_A      3'h2
`define CST_SW_TMR_B      3'h3
`define CST_SW_DUTY1      3'h4
`define CST_SW_DUTY2      3'h5

// Wake cyclic filter select
`define CST_WK_TMR_A      2'h2
`define CST_WK_TMR_B      2'h3

// Timing
`define CST_CLK_NS        10
`define CST_TICK_NS       10000
`define CST_TICK_CYC      (`CST_TICK_NS / `CST_CLK_NS)
`define CST_WK_FILT_NS    16000
`define CST_WK_FILT_CYC   (`CST_WK_FILT_NS / `CST_CLK_NS)
`define CST_ON1_US        100
`define CST_ON2_US        300
`define CST_ON3_US        1000
`define CST_ON4_US        10000
`define CST_ON5_US        20000
`define CST_PER0_MS       10
`define CST_PER1_MS       20
`define CST_PER2_MS       50
`define CST_PER3_MS       100
`define CST_PER4_MS       200
`define CST_PER5_MS       1000
`define CST_PER6_MS       2000

`endif

// file: dv/cst_timers_asserts.sv
// Port checker for the cyclic timer and switch shutdown block
`timescale 1ns/100ps
`default_nettype none
module cst_timers_chk #(
  parameter FILT_CYC = 4
) (
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       soft_rst,
  input wire logic       restart,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic       supply_ov,
  input wire logic       supply_uv,
  input wire logic [1:0] wake_cyc_sel,
  input wire logic       wake_in,
  input wire logic [3:0] high_side_output_q,
  input wire logic       wake_event_q,
  input wire logic       supply_clear_q
);
  logic [2:0]  sd_q;
  logic [15:0] wk_q;
  // Shadow of the inhibit and recovery bits, restart keeps them
  always_ff @(posedge core_clk) begin
    if (!nrst || soft_rst)
      sd_q <= 3'h0;
    else if (reg_wr && reg_addr == 7'h10)
      sd_q <= reg_wdata[6:4];
  end
  // Run length of wake high, wraps only after far longer than any test
  always_ff @(posedge core_clk) begin
    wk_q <= wake_in ? wk_q + 16'h1 : 16'h0;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_rd_sd;
    reg_rd && reg_addr == 7'h10;
  endsequence
  sequence s_rd_unm;
    reg_rd && !(reg_addr inside {7'h0C, 7'h0D, 7'h10, 7'h14});
  endsequence
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata_q == 8'h00)
    else $error("read data not idle");
  a_rsvd_bits: assert property (reg_rd |=> !reg_rdata_q[7] && !reg_rdata_q[3])
    else $error("reserved bit read as one");
  a_sd_low_bits: assert property (s_rd_sd |=> reg_rdata_q[3:0] == 4'h0)
    else $error("shutdown low bits not zero");
  a_unmapped_zero: assert property (s_rd_unm |=> reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  a_fault_off: assert property ((supply_ov && !sd_q[2]) || (supply_uv && !sd_q[1])
    |=> high_side_output_q == 4'h0)
    else $error("switches on during supply fault");
  a_clear_pulse: assert property (supply_clear_q |=> !supply_clear_q)
    else $error("clear pulse too long");
  a_clear_cause: assert property (supply_clear_q |-> $past(supply_ov || supply_uv)
    && !$past(sd_q[0]))
    else $error("clear pulse without fault");
  a_wake_pulse: assert property (wake_event_q |=> !wake_event_q)
    else $error("wake pulse too long");
  a_wake_filter: assert property (wake_event_q |-> $past(wake_cyc_sel[1])
    && wk_q >= FILT_CYC - 1)
    else $error("wake without filtered level");
  a_reset_off: assert property (soft_rst || restart |-> ##2 high_side_output_q[1:0] == 2'h0)
    else $error("switch on after reset");
endmodule
bind cst_timers cst_timers_chk #(.FILT_CYC(FILT_CYC)) i_chk (
  .core_clk(core_clk), .nrst(nrst), .soft_rst(soft_rst), .restart(restart),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .supply_ov(supply_ov), .supply_uv(supply_uv),
  .wake_cyc_sel(wake_cyc_sel), .wake_in(wake_in), .high_side_output_q(high_side_output_q),
  .wake_event_q(wake_event_q), .supply_clear_q(supply_clear_q));
`default_nettype wire

// file: dv/test_cst_timers.sv
// Self-checking bench for the cyclic timer and switch shutdown block
`timescale 1ns/100ps
`default_nettype none
module test_cst_timers;
  localparam int TK = 2;
  logic       core_clk = 1'b0;
  logic       nrst = 1'b0;
  logic       soft_rst = 1'b0;
  logic       restart = 1'b0;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       ov = 1'b0;
  logic       uv = 1'b0;
  logic       duty1 = 1'b0;
  logic       duty2 = 1'b0;
  logic [2:0] sw4 = 3'h0;
  logic       wake_in = 1'b0;
  logic       wake_ev;
  logic       sclr;
  logic [1:0] sw_fault = 2'h0;
  logic [1:0] wsel = 2'h0;
  logic [2:0] sw3 = 3'h0;
  logic [3:0] hso;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata_q;
  int         num_errors = 0;
  int         n_compared = 0;
  logic [6:0] ra [4] = '{7'h0C, 7'h0D, 7'h10, 7'h14};
  logic [7:0] rv [4] = '{8'h77, 8'h77, 8'h70, 8'h77};
  logic [7:0] tv [5] = '{8'h10, 8'h20, 8'h31, 8'h42, 8'h53};
  int         ous [5] = '{100, 300, 1000, 10000, 20000};
  int         pms [5] = '{10, 10, 20, 50, 100};
  always #5 core_clk = ~core_clk;
  // Short tick so that millisecond figures stay affordable
  cst_timers #(.TICK_CYC(TK), .FILT_CYC(4)) i_dut (
    .core_clk(core_clk), .nrst(nrst), .soft_rst(soft_rst), .restart(restart),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .supply_ov(ov), .supply_uv(uv), .sw_fault(sw_fault),
    .switch_three_config(sw3), .switch_four_config(sw4), .duty_channel_one(duty1),
    .duty_channel_two(duty2), .wake_cyc_sel(wsel), .wake_in(wake_in),
    .high_side_output_q(hso), .wake_event_q(wake_ev), .supply_clear_q(sclr));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
    n_compared++;
    if (got !== exp && (tol == 0 || got + tol < exp || got > exp + tol)) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data only stand in the cycle after the strobe
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata_q, e, 0);
  endtask
  // Write plus timer and output stages need three edges
  task automatic out(input logic [3:0] e);
    repeat (4) @(posedge core_clk);
    #1;
    chk(hso, e, 0);
  endtask
  task automatic run(input logic v, output int k);
    k = 0;
    while (hso[0] === v && k < 50000) begin
      @(posedge core_clk);
      #1;
      k++;
    end
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence
  initial begin
    int   n;
    int   m;
    logic seen;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++) rd(ra[i], 8'h00);
    for (int i = 0; i < 4; i++) wr(ra[i], 8'hFF);
    wr(7'h0E, 8'hFF);
    for (int i = 0; i < 4; i++) rd(ra[i], rv[i]);
    rd(7'h0E, 8'h00);
    @(posedge core_clk) restart <= 1'b1;
    @(posedge core_clk) restart <= 1'b0;
    for (int i = 0; i < 4; i++) rd(ra[i], (i == 2) ? 8'h70 : 8'h00);
    @(posedge core_clk) soft_rst <= 1'b1;
    @(posedge core_clk) soft_rst <= 1'b0;
    rd(7'h10, 8'h00);
    // Every switch code against static timer levels and a duty level
    wr(7'h0C, 8'h60);
    wr(7'h0D, 8'h00);
    sw3 <= 3'h4;
    sw4 <= 3'h5;
    duty1 <= 1'b1;
    duty2 <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(7'h14, 8'(c));
      out({2'b11, 1'b0, c == 1 || c == 2 || c == 4 || c == 5});
    end
    @(posedge core_clk) duty1 <= 1'b0;
    duty2 <= 1'b0;
    out(4'h0);
    wr(7'h14, 8'h02);
    wr(7'h0C, 8'h77);
    out(4'h0);
    // Supply faults with and without inhibit and recovery
    wr(7'h14, 8'h11);
    @(posedge core_clk) ov <= 1'b1;
    @(posedge core_clk);
    #1;
    chk(sclr, 1'b1, 0);
    out(4'h0);
    rd(7'h14, 8'h00);
    @(posedge core_clk) ov <= 1'b0;
    out(4'h0);
    wr(7'h10, 8'h40);
    wr(7'h14, 8'h01);
    ov <= 1'b1;
    out(4'h1);
    @(posedge core_clk) ov <= 1'b0;
    wr(7'h10, 8'h20);
    uv <= 1'b1;
    out(4'h1);
    wr(7'h10, 8'h10);
    @(posedge core_clk);
    #1;
    chk(sclr, 1'b0, 0);
    out(4'h0);
    rd(7'h14, 8'h01);
    @(posedge core_clk) uv <= 1'b0;
    out(4'h1);
    wr(7'h14, 8'h11);
    sw_fault <= 2'h1;
    rd(7'h14, 8'h10);
    @(posedge core_clk) sw_fault <= 2'h0;
    wr(7'h14, 8'h11);
    sw_fault <= 2'h2;
    rd(7'h14, 8'h01);
    @(posedge core_clk) sw_fault <= 2'h0;
    // Each timer drives its switch and times the wake sample in turn
    wr(7'h14, 8'h32);
    wake_in <= 1'b1;
    for (int w = 2; w < 4; w++) begin
      @(posedge core_clk) wsel <= 2'(w);
      wr(7'(10 + w), 8'h10);
      n = 0;
      seen = 1'b0;
      while (wake_ev !== 1'b1 && n < 2100) begin
        @(posedge core_clk);
        #1;
        seen |= hso[w - 2];
        n++;
      end
      chk({seen, wake_ev}, 2'b11, 0);
    end
    // Second full cycle only, the first is cut by the restart of the count
    for (int i = 0; i < 5; i++) begin
      wr(7'h0C, tv[i]);
      repeat (4) @(posedge core_clk);
      #1;
      run(1'b1, n);
      run(1'b0, m);
      run(1'b1, n);
      chk(n, ous[i] / 10 * TK, 2);
      chk(n + m, pms[i] * 100 * TK, 2);
    end
    wrap_up();
  end
  // Watchdog against a hang
  initial begin
    #1_000_000;
    num_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
